// ===== rtl/dcir_bank.sv
// register bank for external diode ideality, averaging and identity
// assumes the serial front end supplies synchronous one-cycle accesses
`timescale 1ns/1ns
`default_nettype none
module dcir_bank #(
  parameter logic [7:0] PART_CODE     = 8'ha5, // arbitrary value
  parameter logic [7:0] MAKER_CODE    = 8'h3c, // arbitrary value
  parameter logic [7:0] REV_CODE_A    = 8'h11, // arbitrary value
  parameter logic [7:0] REV_CODE_B    = 8'h12  // arbitrary value
) (
  input  wire logic                      CLOCK,
  input  wire logic                      SYS_RST,
  input  wire dcir_pkg::dcir_access_type ACCESS,
  input  wire logic                      REV_SELECT,
  input  wire logic                      TRANSISTOR_MODEL,
  output logic [7:0]                     READ_DATA,
  output logic [5:0]                     IDEALITY_CODE,
  output logic [15:0]                    IDEALITY_FACTOR,
  output logic                           FACTOR_VALID,
  output dcir_pkg::dcir_avg_type         AVERAGING_LEVEL
);
  import dcir_pkg::*;

  // ***********************************************************
  // decode helpers
  // ***********************************************************
  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input logic [5:0] ideal,
                                          input logic [1:0] avg,
                                          input logic [7:0] rev);
    logic [7:0] r;
    r = 8'h00;
    if (a == IDEALITY_ADDR) begin
      r = {2'h0, ideal};
    end else if (a == AVERAGING_ADDR) begin
      r = {6'h00, avg};
    end else if (a == PART_ADDR) begin
      r = PART_CODE;
    end else if (a == MAKER_ADDR) begin
      r = MAKER_CODE;
    end else if (a == REVISION_ADDR) begin
      r = rev;
    end
    return r;
  endfunction

  function automatic dcir_avg_type avg_decode(input logic [1:0] s);
    dcir_avg_type l;
    l = AVG_OFF;
    case (s)
      2'h0: l = AVG_OFF;
      2'h1, 2'h2: l = AVG_LEVEL1;
      default: l = AVG_LEVEL2;
    endcase
    return l;
  endfunction

  function automatic logic code_in_table(input logic [5:0] code);
    return (code >= IDEALITY_LOW) && (code <= IDEALITY_HIGH);
  endfunction

  // ***********************************************************
  // diode model factors, 0.0001 units; transistor model is 80 lower
  // ***********************************************************
  function automatic logic [15:0] diode_factor(input logic [5:0] code);
    logic [15:0] f;
    f = 16'h0000;
    case (code)
      6'h08: f = DIODE_FACTOR_AT_LOW;
      6'h09: f = 16'h26ea;
      6'h0a: f = 16'h26f7;
      6'h0b: f = 16'h2704;
      6'h0c: f = 16'h2711;
      6'h0d: f = 16'h271e;
      6'h0e: f = 16'h272b;
      6'h0f: f = 16'h2738;
      6'h10: f = 16'h2745;
      6'h11: f = 16'h2752;
      6'h12: f = 16'h2760;
      6'h13: f = 16'h276d;
      6'h14: f = 16'h277a;
      6'h15: f = 16'h2787;
      6'h16: f = 16'h2795;
      6'h17: f = 16'h27a2;
      6'h18: f = 16'h27af;
      6'h19: f = 16'h27bc;
      6'h1a: f = 16'h27c9;
      6'h1b: f = 16'h27d8;
      6'h1c: f = 16'h27e4;
      6'h1d: f = 16'h27f2;
      6'h1e: f = 16'h27ff;
      6'h1f: f = 16'h280d;
      6'h20: f = 16'h281b;
      6'h21: f = 16'h2828;
      6'h22: f = 16'h2835;
      6'h23: f = 16'h2842;
      6'h24: f = 16'h284f;
      6'h25: f = 16'h285c;
      6'h26: f = 16'h2869;
      6'h27: f = 16'h2876;
      6'h28: f = 16'h2883;
      6'h29: f = 16'h2890;
      6'h2a: f = 16'h289d;
      6'h2b: f = 16'h28aa;
      6'h2c: f = 16'h28b7;
      6'h2d: f = 16'h28c4;
      6'h2e: f = 16'h28d1;
      6'h2f: f = 16'h28de;
      6'h30: f = 16'h28eb;
      6'h31: f = 16'h28f8;
      6'h32: f = 16'h2905;
      6'h33: f = 16'h2912;
      6'h34: f = 16'h291f;
      6'h35: f = 16'h292c;
      6'h36: f = 16'h2939;
      6'h37: f = 16'h2946;
      default: f = 16'h0000;
    endcase
    return f;
  endfunction

  // ***********************************************************
  // register state
  // ***********************************************************
  logic [5:0]   ideality;
  logic [1:0]   averaging;
  dcir_avg_type level;
  logic [7:0]   rev_code;
  logic [7:0]   read_data;
  logic [15:0]  factor;
  logic         factor_ok;

  logic [5:0]   next_ideality;
  logic [1:0]   next_averaging;
  dcir_avg_type next_level;
  logic [7:0]   next_rev_code;
  logic [7:0]   next_read_data;
  logic [15:0]  next_factor;
  logic         next_factor_ok;

  // ***********************************************************
  // writable configuration
  // ***********************************************************
  always_comb begin
    next_ideality  = ideality;
    next_averaging = averaging;
    if (ACCESS.write) begin
      if (ACCESS.addr == IDEALITY_ADDR) begin
        next_ideality = ACCESS.wdata[IDEALITY_MSB:0];
      end else if (ACCESS.addr == AVERAGING_ADDR) begin
        next_averaging = ACCESS.wdata[AVERAGING_MSB:0];
      end
      // identity addresses have no write path
    end
    next_level = avg_decode(next_averaging);
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ideality  <= IDEALITY_RESET;
      averaging <= AVERAGING_RESET;
      level     <= AVG_OFF;
    end else begin
      ideality  <= next_ideality;
      averaging <= next_averaging;
      level     <= next_level;
    end
  end

  // ***********************************************************
  // read path and revision select
  // ***********************************************************
  always_comb begin
    // revision pin sampled once per clock
    next_rev_code  = REV_SELECT ? REV_CODE_B : REV_CODE_A;
    next_read_data = read_data;
    if (ACCESS.read) begin
      // unmapped reads return zero
      next_read_data = read_mux(ACCESS.addr, ideality, averaging, rev_code);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rev_code  <= REV_CODE_A;
      read_data <= 8'h00;
    end else begin
      rev_code  <= next_rev_code;
      read_data <= next_read_data;
    end
  end

  // ***********************************************************
  // ideality factor lookup
  // ***********************************************************
  always_comb begin
    next_factor_ok = code_in_table(ideality);
    // codes outside the table give zero
    next_factor = diode_factor(ideality);
    if (TRANSISTOR_MODEL && next_factor_ok) begin
      next_factor = 16'(next_factor - TRANS_OFFSET);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      factor    <= 16'h0000;
      factor_ok <= 1'b0;
    end else begin
      factor    <= next_factor;
      factor_ok <= next_factor_ok;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign READ_DATA       = read_data;
  assign IDEALITY_CODE   = ideality;
  assign IDEALITY_FACTOR = factor;
  assign FACTOR_VALID    = factor_ok;
  assign AVERAGING_LEVEL = level;

endmodule // dcir_bank
`default_nettype wire

// ===== rtl/dcir_pkg.sv
// constants and carrier types for the diode configuration and identity bank
// assumes a serial register front end that presents one access per cycle
package dcir_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] IDEALITY_ADDR  = 8'h27;
  localparam logic [7:0] AVERAGING_ADDR = 8'h40;
  localparam logic [7:0] PART_ADDR      = 8'hfd;
  localparam logic [7:0] MAKER_ADDR     = 8'hfe;
  localparam logic [7:0] REVISION_ADDR  = 8'hff;

  // ***********************************************************
  // fields and reset values
  // ***********************************************************
  localparam int         IDEALITY_MSB   = 5;
  localparam int         AVERAGING_MSB  = 1;
  localparam logic [5:0] IDEALITY_RESET = 6'h12;
  localparam logic [1:0] AVERAGING_RESET = 2'h0;
  localparam logic [5:0] IDEALITY_LOW   = 6'h08;
  localparam logic [5:0] IDEALITY_HIGH  = 6'h37;

  // factors in units of 0.0001; code 12h is 10080 and 10000
  localparam logic [15:0] DIODE_FACTOR_AT_LOW = 16'h26dd;
  localparam logic [15:0] TRANS_OFFSET        = 16'h0050;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {
    AVG_OFF,
    AVG_LEVEL1,
    AVG_LEVEL2
  } dcir_avg_type;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcir_access_type;

endpackage : dcir_pkg

// ===== sim/dcir_bank_monitor.sv
// checker on the bank ports
// assumes bind onto dcir_bank
`timescale 1ns/1ns
`default_nettype none
module dcir_bank_monitor (
  input wire logic                      CLOCK,
  input wire logic                      SYS_RST,
  input wire dcir_pkg::dcir_access_type ACCESS,
  input wire logic                      TRANSISTOR_MODEL,
  input wire logic [7:0]                READ_DATA,
  input wire logic [5:0]                IDEALITY_CODE,
  input wire logic [15:0]               IDEALITY_FACTOR,
  input wire logic                      FACTOR_VALID,
  input wire dcir_pkg::dcir_avg_type    AVERAGING_LEVEL
);
  import dcir_pkg::*;
  // ****************
  // assertions
  // ****************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire logic         rd = ACCESS.read;
  wire logic         wr = ACCESS.write;
  wire logic [7:0]   ad = ACCESS.addr;
  wire logic [5:0]   ic = IDEALITY_CODE;
  wire logic [1:0]   f  = ACCESS.wdata[1:0];
  wire dcir_avg_type lv = f == 2'h0 ? AVG_OFF : &f ? AVG_LEVEL2 : AVG_LEVEL1;
  property p_rd;
    rd && ad == 8'h27 |=> READ_DATA == {2'h0, $past(ic)};
  endproperty
  a_rd: assert property (p_rd) else $error("ideality read");
  property p_wr;
    wr && ad == 8'h27 |=> ic == $past(ACCESS.wdata[5:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("ideality write");
  property p_rst; $past(SYS_RST) |-> ic == 6'h12 && AVERAGING_LEVEL == AVG_OFF;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_fd; (!TRANSISTOR_MODEL && ic == 6'h12) [*3] |-> IDEALITY_FACTOR ==
    16'h2760; endproperty
  a_fd: assert property (p_fd) else $error("diode factor");
  property p_ft; (TRANSISTOR_MODEL && ic == 6'h12) [*3] |-> IDEALITY_FACTOR ==
    16'h2710; endproperty
  a_ft: assert property (p_ft) else $error("transistor factor");
  property p_av;
    wr && ad == 8'h40 |=> AVERAGING_LEVEL == $past(lv);
  endproperty
  a_av: assert property (p_av) else $error("averaging level");
  property p_r40; rd && ad == 8'h40 |=> READ_DATA[7:2] == 6'h00; endproperty
  a_r40: assert property (p_r40) else $error("unused bits");
  property p_va;
    $stable(ic) [*3] |-> FACTOR_VALID == (ic inside {[6'h08:6'h37]});
  endproperty
  a_va: assert property (p_va) else $error("factor valid");
  c_w27: cover property (wr && ad == 8'h27);
  c_w40: cover property (wr && ad == 8'h40);
  c_tm: cover property (TRANSISTOR_MODEL && IDEALITY_FACTOR == 16'h2710);
endmodule // dcir_bank_monitor
bind dcir_bank dcir_bank_monitor mon (
  .CLOCK            (CLOCK),
  .SYS_RST          (SYS_RST),
  .ACCESS           (ACCESS),
  .TRANSISTOR_MODEL (TRANSISTOR_MODEL),
  .READ_DATA        (READ_DATA),
  .IDEALITY_CODE    (IDEALITY_CODE),
  .IDEALITY_FACTOR  (IDEALITY_FACTOR),
  .FACTOR_VALID     (FACTOR_VALID),
  .AVERAGING_LEVEL  (AVERAGING_LEVEL)
);
`default_nettype wire

// ===== sim/dcir_host.sv
// host model making single byte register accesses
// assumes callers accept one idle cycle between accesses
`timescale 1ns/1ns
`default_nettype none
module dcir_host (
  input  wire logic                      CLOCK,
  input  wire logic [7:0]                READ_DATA,
  output var dcir_pkg::dcir_access_type  ACCESS
);
  import dcir_pkg::*;
  initial ACCESS = '0;
  task automatic xfer(logic w, logic [7:0] a, d, output logic [7:0] r);
    @(posedge CLOCK) #1;
    ACCESS = '{w, !w, a, d};
    @(posedge CLOCK) #1;
    ACCESS = '{1'b0, 1'b0, ~a, ~d};
    r = READ_DATA;
  endtask
endmodule // dcir_host
`default_nettype wire

// ===== sim/tb.sv
// bench for the diode configuration and identity bank
// assumes dcir_host makes the register accesses
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dcir_pkg::*;
  logic CLOCK = 0, SYS_RST = 1, REV_SELECT = 0, TRANSISTOR_MODEL = 0, fv;
  logic [7:0]      rd;
  logic [15:0]     fac;
  dcir_avg_type    lvl;
  dcir_access_type acc;
  int n_fail = 0, checks = 0, cyc = 0;
  initial forever #20 CLOCK = ~CLOCK;
  dcir_bank uut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ACCESS(acc),
    .REV_SELECT(REV_SELECT), .TRANSISTOR_MODEL(TRANSISTOR_MODEL),
    .READ_DATA(rd), .IDEALITY_CODE(), .IDEALITY_FACTOR(fac),
    .FACTOR_VALID(fv), .AVERAGING_LEVEL(lvl));
  dcir_host host (.CLOCK(CLOCK), .READ_DATA(rd), .ACCESS(acc));
  task automatic chk(string n, logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  task automatic wr(logic [7:0] a, d);
    logic [7:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rdc(string n, logic [7:0] a, e);
    logic [7:0] x;
    host.xfer(1'b0, a, 8'h00, x);
    chk(n, {8'h0, x}, {8'h0, e});
  endtask
  task automatic wfv(logic [7:0] c, logic e);
    wr(8'h27, c);
    @(posedge CLOCK) #1;
    chk("valid", {15'h0, fv}, {15'h0, e});
  endtask
  task automatic t_reset;
    rdc("ideality", 8'h27, 8'h12);
    rdc("averaging", 8'h40, 8'h00);
    chk("factor", fac, 16'h2760);
  endtask
  task automatic t_ideal;
    wfv(8'h07, 1'b0);
    wfv(8'h08, 1'b1);
    chk("factor", fac, DIODE_FACTOR_AT_LOW);
    wfv(8'h37, 1'b1);
    chk("factor", fac, 16'h2946);
    wfv(8'hff, 1'b0);
    chk("factor", fac, 16'h0000);
    rdc("ideality", 8'h27, 8'h3f);
    wr(8'h27, 8'h15);
    @(posedge CLOCK) #1;
    chk("factor", fac, 16'h2787);
    TRANSISTOR_MODEL = 1;
    wr(8'h27, 8'h12);
    @(posedge CLOCK) #1;
    chk("factor", fac, 16'h2710);
    repeat (3) @(posedge CLOCK);
    #1 TRANSISTOR_MODEL = 0;
  endtask
  task automatic t_avg;
    dcir_avg_type e[4] = '{AVG_OFF, AVG_LEVEL1, AVG_LEVEL1, AVG_LEVEL2};
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, 8'hfc | i[7:0]);
      chk("level", {14'h0, lvl}, {14'h0, e[i]});
      rdc("averaging", 8'h40, i[7:0]);
    end
  endtask
  task automatic t_id;
    wr(8'hfd, 8'h00);
    wr(8'hfe, 8'h00);
    wr(8'hff, 8'h00);
    rdc("part", 8'hfd, 8'ha5);
    rdc("maker", 8'hfe, 8'h3c);
    rdc("unmapped", 8'h80, 8'h00);
    rdc("rev_a", 8'hff, 8'h11);
    REV_SELECT = 1;
    rdc("rev_b", 8'hff, 8'h12);
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    #1 SYS_RST = 0;
    t_reset;
    t_ideal;
    t_avg;
    t_id;
    stop_test;
  end
endmodule // tb
`default_nettype wire
